// file: hdl/cpwm_cfg.svh
// constants of the complementary pwm output block: offsets, fields, codes
// assumes a word-addressed register port with 16-bit data
`ifndef CPWM_CFG_SVH
`define CPWM_CFG_SVH
// ************************************************************
// widths
// ************************************************************
`define CPWM_DW        16
`define CPWM_AW        5
// ************************************************************
// register offsets (word index on the register port)
// ************************************************************
`define CPWM_OFS_MODE  5'h00
`define CPWM_OFS_OCTL  5'h01
`define CPWM_OFS_GATE  5'h02
`define CPWM_OFS_SYNC  5'h03
`define CPWM_OFS_DEAD  5'h04
`define CPWM_OFS_CMP0  5'h05
`define CPWM_OFS_CMP4  5'h09
`define CPWM_OFS_BUF0  5'h0A
`define CPWM_OFS_BUF4  5'h0E
`define CPWM_OFS_CNTA  5'h0F
`define CPWM_OFS_CNTB  5'h10
`define CPWM_OFS_CNTS  5'h11
`define CPWM_OFS_PROT  5'h12
`define CPWM_OFS_STAT  5'h13
// ************************************************************
// slot indices inside the five buffered registers
// ************************************************************
`define CPWM_SLOT_CYC  3'h0
`define CPWM_SLOT_HALF 3'h1
`define CPWM_SLOT_U    3'h2
`define CPWM_SLOT_LAST 3'h4
// ************************************************************
// field positions
// ************************************************************
`define CPWM_MD_LSB    0
`define CPWM_OC_PLS    0
`define CPWM_OC_NLS    3
`define CPWM_OC_TOG    6
`define CPWM_OC_ADC    7
`define CPWM_OC_RUN    8
`define CPWM_GC_DRV    0
`define CPWM_GC_FB     1
`define CPWM_GC_PH     2
`define CPWM_GC_PCH    5
`define CPWM_GC_NCH    6
`define CPWM_SY_EN     0
`define CPWM_SY_CLR    1
`define CPWM_PROT_BIT  13
// ************************************************************
// codes and reset values
// ************************************************************
`define CPWM_MD_CREST  4'hD
`define CPWM_MD_TROUGH 4'hE
`define CPWM_MD_BOTH   4'hF
`define CPWM_CLR_SYNC  3'h3
`define CPWM_RST_ZERO  16'h0000
`define CPWM_RST_PROT  16'h2000
`endif

// file: hdl/cpwm_pkg.sv
// types of the complementary pwm output block
// assumes cpwm_cfg.svh gives the widths
`include "cpwm_cfg.svh"
package cpwm_pkg;
  // one register port request
  typedef struct packed {
    logic [`CPWM_AW-1:0] addr;
    logic [`CPWM_DW-1:0] wdata;
    logic                wr;
    logic                rd;
  } cpwm_bus_req_t;
  // mode sequencing, gray coded along idle, init, run
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN  = 2'b11
  } cpwm_state_t;
  // on state of one phase pair
  typedef struct packed {
    logic neg;
    logic pos;
  } cpwm_pair_t;
endpackage

// file: hdl/cpwm_top.sv
// complementary three-phase pwm output with buffered duty and cycle update
// assumes one 10 MHz clock, a cpu register port, hall pins and
// shutdown pins arriving asynchronously, sync clear from a timer channel
`timescale 1ns/1ps
`include "cpwm_cfg.svh"
// Behaviour
// - idle subcounter: buffer write reaches temporary
// - subcounter running: transfer waits until stop
// - temporary to compare at selected crest/trough
// - last duty write moves all five
// - outputs inactive until counter b passes dead
// - compare matches drive outputs, temporaries compared while subcounter runs
// - turn-off taken unless its own turn-on coincides, early turn-on ignored
// - off from leading counter, on lagging
// - duty zero gives positive always on
// - duty equal cycle gives positive off
// - simultaneous on and off both ignored
// - toggle pin starts one, toggles crest/trough
// - synchronous clear reloads all three counters, a from dead, b and s to zero
// - hall edges switch motor outputs
// - phase bits switch motor outputs
// - chop enable selects pwm or level
// - level selects set motor active level
// - cycle match issues conversion start request
// - access bit guards mode, control, compare, counters
// - shutdown pins float all six outputs
// - clock halt floats all six outputs
// - temporary registers hidden from cpu
module cpwm_top #(
  parameter int CW = `CPWM_DW
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // register port
  input  wire cpwm_pkg::cpwm_bus_req_t bus_req,
  output logic [CW-1:0]              rd_data,
  // position and protection inputs
  input  wire logic [2:0]            hall_in,
  input  wire logic [3:0]            shutdown_in,
  input  wire logic                  clk_halt_in,
  input  wire logic                  sync_clear_in,
  // pwm pins, bits 2:0 positive u v w, bits 5:3 negative u v w
  output logic [5:0]                 pwm_out,
  output logic [5:0]                 pwm_oe,
  // carrier toggle pin and converter trigger
  output logic                       toggle_out,
  output logic                       adc_start_req
);
  // ************************************************************
  // elaboration check
  // ************************************************************
  if (CW != `CPWM_DW) begin : g_chk
    $error("cpwm_top supports only the package data width");
  end

  // ************************************************************
  // functions
  // ************************************************************
  // counter equals compare value
  function automatic logic hit(input logic [CW-1:0] c,
                               input logic [CW-1:0] v);
    hit = (c == v);
  endfunction

  // six-step table: position to {negative on, positive on}
  function automatic logic [5:0] commute(input logic [2:0] p);
    unique case (p)
      3'b101:  commute = 6'b010_001;
      3'b100:  commute = 6'b100_001;
      3'b110:  commute = 6'b100_010;
      3'b010:  commute = 6'b001_010;
      3'b011:  commute = 6'b001_100;
      3'b001:  commute = 6'b010_100;
      default: commute = 6'b000_000;
    endcase
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  localparam logic [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};
  cpwm_pkg::cpwm_state_t st_q, st_d;
  logic [CW-1:0] mode_q, octl_q, gate_q, sync_q, dead_q, prot_q;
  logic [CW-1:0] cmp_q  [0:4];
  logic [CW-1:0] buf_q  [0:4];
  logic [CW-1:0] tmp_q  [0:4];
  logic [CW-1:0] cnt_a_q, cnt_b_q, cnt_s_q;
  logic          up_q, pend_q, sub_run_q;
  cpwm_pkg::cpwm_pair_t pair_q [0:2];
  logic [2:0]    hall_s1_q, hall_s2_q;
  logic [3:0]    shut_s1_q, shut_s2_q;
  logic          halt_s1_q, halt_s2_q;
  logic [CW-1:0] rdata_q;
  logic [5:0]    pwm_q, oe_q;
  logic          tog_q, adc_q;

  // ************************************************************
  // register decode
  // ************************************************************
  wire [`CPWM_AW-1:0] adr   = bus_req.addr;
  wire [CW-1:0]       wdat  = bus_req.wdata;
  wire                acc_ok = prot_q[`CPWM_PROT_BIT];
  wire                wr_g  = bus_req.wr & acc_ok;
  wire                wr_mode = wr_g & (adr == `CPWM_OFS_MODE);
  wire                wr_octl = wr_g & (adr == `CPWM_OFS_OCTL);
  wire                wr_gate = wr_g & (adr == `CPWM_OFS_GATE);
  wire                wr_sync = wr_g & (adr == `CPWM_OFS_SYNC);
  wire                wr_dead = wr_g & (adr == `CPWM_OFS_DEAD);
  wire                wr_cnta = wr_g & (adr == `CPWM_OFS_CNTA);
  wire                wr_cntb = wr_g & (adr == `CPWM_OFS_CNTB);
  wire                wr_prot = bus_req.wr & (adr == `CPWM_OFS_PROT);
  wire                in_cmp  = (adr >= `CPWM_OFS_CMP0) &
                                (adr <= `CPWM_OFS_CMP4);
  wire                in_buf  = (adr >= `CPWM_OFS_BUF0) &
                                (adr <= `CPWM_OFS_BUF4);
  wire [2:0]          cmp_idx = 3'(adr - `CPWM_OFS_CMP0);
  wire [2:0]          buf_idx = 3'(adr - `CPWM_OFS_BUF0);
  wire                wr_cmp  = wr_g & in_cmp;
  wire                wr_buf  = bus_req.wr & in_buf;         // always open
  wire                wr_last = wr_buf & (buf_idx == `CPWM_SLOT_LAST);

  // ************************************************************
  // control fields
  // ************************************************************
  wire [3:0] md       = mode_q[`CPWM_MD_LSB +: 4];
  wire       md_on    = (md == `CPWM_MD_CREST) | (md == `CPWM_MD_TROUGH) |
                        (md == `CPWM_MD_BOTH);
  wire       upd_crest  = (md == `CPWM_MD_CREST) | (md == `CPWM_MD_BOTH);
  wire       upd_trough = (md == `CPWM_MD_TROUGH) | (md == `CPWM_MD_BOTH);
  wire [2:0] pos_level_sel = octl_q[`CPWM_OC_PLS +: 3];
  wire [2:0] neg_level_sel = octl_q[`CPWM_OC_NLS +: 3];
  wire       cycle_toggle_enable = octl_q[`CPWM_OC_TOG];
  wire       adc_trigger_enable  = octl_q[`CPWM_OC_ADC];
  wire       run_en   = octl_q[`CPWM_OC_RUN];
  wire       drive_en = gate_q[`CPWM_GC_DRV];
  wire       feedback_source_sel = gate_q[`CPWM_GC_FB];
  wire [2:0] phase_bits      = gate_q[`CPWM_GC_PH +: 3];
  wire       pos_chop_enable = gate_q[`CPWM_GC_PCH];
  wire       neg_chop_enable = gate_q[`CPWM_GC_NCH];
  wire       sync_en    = sync_q[`CPWM_SY_EN];
  wire [2:0] clear_source_field = sync_q[`CPWM_SY_CLR +: 3];

  // ************************************************************
  // counter events
  // ************************************************************
  wire [CW-1:0] limit   = cmp_q[`CPWM_SLOT_CYC];
  wire [CW-1:0] half    = cmp_q[`CPWM_SLOT_HALF];
  wire          counting = (st_q != cpwm_pkg::ST_IDLE) & run_en;
  wire          at_crest  = counting & up_q & hit(cnt_a_q, limit);
  wire          at_trough = counting & ~up_q & hit(cnt_b_q, '0);
  wire          sub_run  = counting & ((cnt_a_q > half) | (cnt_b_q < dead_q));
  wire          sub_stop = sub_run_q & ~sub_run;
  wire          sclr = sync_clear_in & sync_en &
                       (clear_source_field == `CPWM_CLR_SYNC);
  wire          entry = md_on & (st_q == cpwm_pkg::ST_IDLE);
  wire          upd_now = (at_crest & upd_crest) | (at_trough & upd_trough);
  wire          tmp_all = (wr_last & ~sub_run) | (sub_stop & pend_q);
  wire [CW-1:0] lead = up_q ? cnt_a_q : cnt_b_q;
  wire [CW-1:0] lag  = up_q ? cnt_b_q : cnt_a_q;

  // ************************************************************
  // mode sequencing
  // ************************************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      cpwm_pkg::ST_IDLE: if (md_on) st_d = cpwm_pkg::ST_INIT;
      cpwm_pkg::ST_INIT: begin
        if (!md_on) st_d = cpwm_pkg::ST_IDLE;
        else if (cnt_b_q > dead_q) st_d = cpwm_pkg::ST_RUN;
      end
      cpwm_pkg::ST_RUN:  if (!md_on) st_d = cpwm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) st_q <= cpwm_pkg::ST_IDLE;
    else       st_q <= st_d;
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q <= `CPWM_RST_ZERO;
      octl_q <= `CPWM_RST_ZERO;
      gate_q <= `CPWM_RST_ZERO;
      sync_q <= `CPWM_RST_ZERO;
      dead_q <= `CPWM_RST_ZERO;
      prot_q <= `CPWM_RST_PROT;
    end else begin
      if (wr_mode) mode_q <= wdat;
      if (wr_octl) octl_q <= wdat;
      if (wr_gate) gate_q <= wdat;
      if (wr_sync) sync_q <= wdat;
      if (wr_dead) dead_q <= wdat;
      if (wr_prot) prot_q <= wdat;
    end
  end

  // ************************************************************
  // buffer, temporary and compare registers
  // ************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 5; i++) begin
        buf_q[i] <= `CPWM_RST_ZERO;
        tmp_q[i] <= `CPWM_RST_ZERO;
        cmp_q[i] <= `CPWM_RST_ZERO;
      end
      pend_q <= 1'b0;
    end else begin
      if (wr_buf) buf_q[buf_idx] <= wdat;
      if (wr_buf & ~sub_run) tmp_q[buf_idx] <= wdat;
      // a buffer write in this very cycle is newer than the held word
      if (tmp_all) begin
        for (int i = 0; i < 5; i++) begin
          tmp_q[i] <= (wr_buf && buf_idx == 3'(i)) ? wdat : buf_q[i];
        end
      end
      if (wr_last & sub_run) pend_q <= 1'b1;
      else if (sub_stop) pend_q <= 1'b0;
      if (entry) begin
        for (int i = 0; i < 5; i++) cmp_q[i] <= buf_q[i];
      end else if (upd_now) begin
        for (int i = 0; i < 5; i++) cmp_q[i] <= tmp_q[i];
      end else if (wr_cmp) begin
        cmp_q[cmp_idx] <= wdat;
      end
    end
  end

  // ************************************************************
  // carrier counters and subcounter
  // ************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_a_q   <= `CPWM_RST_ZERO;
      cnt_b_q   <= `CPWM_RST_ZERO;
      cnt_s_q   <= `CPWM_RST_ZERO;
      up_q      <= 1'b1;
      sub_run_q <= 1'b0;
    end else begin
      sub_run_q <= sub_run;
      if (entry | sclr) begin
        cnt_a_q <= dead_q;
        cnt_b_q <= '0;
        cnt_s_q <= '0;
        up_q    <= 1'b1;
      end else if (counting) begin
        if (at_crest) begin
          up_q    <= 1'b0;
          cnt_a_q <= cnt_a_q - ONE;
          cnt_b_q <= cnt_b_q - ONE;
        end else if (at_trough) begin
          up_q    <= 1'b1;
          cnt_a_q <= cnt_a_q + ONE;
          cnt_b_q <= cnt_b_q + ONE;
        end else if (up_q) begin
          cnt_a_q <= cnt_a_q + ONE;
          cnt_b_q <= cnt_b_q + ONE;
        end else begin
          cnt_a_q <= cnt_a_q - ONE;
          cnt_b_q <= cnt_b_q - ONE;
        end
        cnt_s_q <= (cnt_a_q > half) ? cnt_a_q : cnt_b_q;
      end else begin
        if (wr_cnta) cnt_a_q <= wdat;
        if (wr_cntb) cnt_b_q <= wdat;
      end
    end
  end

  // ************************************************************
  // per-phase compare and on/off decision
  // ************************************************************
  cpwm_pkg::cpwm_pair_t pair_d [0:2];
  logic [2:0] pos_sel_on, neg_sel_on;
  for (genvar p = 0; p < 3; p++) begin : g_ph
    wire [CW-1:0] duty = cmp_q[`CPWM_SLOT_U + p];
    wire [CW-1:0] tdut = tmp_q[`CPWM_SLOT_U + p];
    // matches against data and, in the subcounter window, temporaries
    wire h_lead = hit(lead, duty) | (sub_run & hit(lead, tdut));
    wire h_lag  = hit(lag, duty)  | (sub_run & hit(lag, tdut));
    wire n_off = counting & up_q  & h_lead;
    wire p_on  = counting & up_q  & h_lag;
    wire p_off = counting & ~up_q & h_lead;
    wire n_on  = counting & ~up_q & h_lag;
    wire full  = (duty == '0);
    wire none  = (duty >= limit);
    // next pair state; off taken unless on coincides, on needs partner off
    always_comb begin
      pair_d[p] = pair_q[p];
      if (full) begin
        pair_d[p] = '{neg: 1'b0, pos: 1'b1};
      end else if (none) begin
        pair_d[p] = '{neg: 1'b1, pos: 1'b0};
      end else begin
        if (p_on & (p_off | n_on)) begin
          pair_d[p].pos = pair_q[p].pos;
        end else if (p_off) begin
          pair_d[p].pos = 1'b0;
        end else if (p_on & (~pair_q[p].neg | n_off)) begin
          pair_d[p].pos = 1'b1;
        end
        if (n_on & (n_off | p_on)) begin
          pair_d[p].neg = pair_q[p].neg;
        end else if (n_off) begin
          pair_d[p].neg = 1'b0;
        end else if (n_on & (~pair_q[p].pos | p_off)) begin
          pair_d[p].neg = 1'b1;
        end
      end
    end
  end

  // commutation pattern from hall pins or software bits
  wire [2:0] pos_src = feedback_source_sel ? phase_bits
                                           : hall_s2_q;
  wire [5:0] comm    = commute(pos_src);

  // on state per pin, motor drive masks and chops
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (drive_en) begin
        pos_sel_on[p] = comm[p] &
                        (pos_chop_enable ? pair_q[p].pos : 1'b1);
        neg_sel_on[p] = comm[p+3] &
                        (neg_chop_enable ? pair_q[p].neg : 1'b1);
      end else begin
        pos_sel_on[p] = pair_q[p].pos;
        neg_sel_on[p] = pair_q[p].neg;
      end
    end
  end

  // pin level: active level when on, else the opposite
  wire       live    = (st_q == cpwm_pkg::ST_RUN);
  wire [2:0] pos_pin = live ? ~(pos_sel_on ^ pos_level_sel)
                            : ~pos_level_sel;
  wire [2:0] neg_pin = live ? ~(neg_sel_on ^ neg_level_sel)
                            : ~neg_level_sel;
  wire       float   = (|shut_s2_q) | halt_s2_q;

  // ************************************************************
  // pair state and input synchronisers
  // ************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < 3; p++) pair_q[p] <= '0;
      hall_s1_q <= '0;
      hall_s2_q <= '0;
      shut_s1_q <= '0;
      shut_s2_q <= '0;
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        pair_q[p] <= (st_q == cpwm_pkg::ST_IDLE) ? '0 : pair_d[p];
      end
      hall_s1_q <= hall_in;
      hall_s2_q <= hall_s1_q;
      shut_s1_q <= shutdown_in;
      shut_s2_q <= shut_s1_q;
      halt_s1_q <= clk_halt_in;
      halt_s2_q <= halt_s1_q;
    end
  end

  // ************************************************************
  // pins, toggle, trigger
  // ************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwm_q <= 6'h00;
      oe_q  <= 6'h00;
      tog_q <= 1'b1;
      adc_q <= 1'b0;
    end else begin
      pwm_q <= {neg_pin, pos_pin};
      oe_q  <= {6{md_on & ~float}};
      if (entry | ~cycle_toggle_enable) tog_q <= 1'b1;
      else if (at_crest | at_trough) tog_q <= ~tog_q;
      adc_q <= adc_trigger_enable & at_crest;
    end
  end

  // ************************************************************
  // read port, data one cycle after the strobe
  // ************************************************************
  wire [CW-1:0] stat = {{(CW-5){1'b0}}, pend_q, sub_run, up_q, st_q};
  logic [CW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (adr)
      `CPWM_OFS_MODE: rd_mux = acc_ok ? mode_q : '0;
      `CPWM_OFS_OCTL: rd_mux = acc_ok ? octl_q : '0;
      `CPWM_OFS_GATE: rd_mux = acc_ok ? gate_q : '0;
      `CPWM_OFS_SYNC: rd_mux = acc_ok ? sync_q : '0;
      `CPWM_OFS_DEAD: rd_mux = acc_ok ? dead_q : '0;
      `CPWM_OFS_CNTA: rd_mux = acc_ok ? cnt_a_q : '0;
      `CPWM_OFS_CNTB: rd_mux = acc_ok ? cnt_b_q : '0;
      `CPWM_OFS_CNTS: rd_mux = acc_ok ? cnt_s_q : '0;
      `CPWM_OFS_PROT: rd_mux = prot_q;
      `CPWM_OFS_STAT: rd_mux = stat;
      default: begin
        if (in_cmp & acc_ok) rd_mux = cmp_q[cmp_idx];
        else if (in_buf) rd_mux = buf_q[buf_idx];
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset)            rdata_q <= '0;
    else if (bus_req.rd)  rdata_q <= rd_mux;
    else                  rdata_q <= '0;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rd_data       = rdata_q;
  assign pwm_out       = pwm_q;
  assign pwm_oe        = oe_q;
  assign toggle_out    = tog_q;
  assign adc_start_req = adc_q;

endmodule // cpwm_top

// file: test/cpwm_top_asserts.sv
// port checker for the complementary pwm output block
// assumes it is bound onto cpwm_top, one clock, async high reset
`timescale 1ns/1ps
module cpwm_top_chk #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    reset,
  // register port
  input wire cpwm_pkg::cpwm_bus_req_t bus_req,
  input wire logic [CW-1:0]           rd_data,
  // protection inputs
  input wire logic [3:0]              shutdown_in,
  input wire logic                    clk_halt_in,
  // outputs
  input wire logic [5:0]              pwm_oe,
  input wire logic                    toggle_out,
  input wire logic                    adc_start_req
);
  // ************************************************************
  // port relations
  // ************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rd_data == '0)
    else $error("read data not zero outside read answer");
  AST_RD_UNMAP: assert property (bus_req.rd && bus_req.addr > 5'h13
    |=> rd_data == '0) else $error("unmapped read not zero");
  AST_BUF_RD: assert property ((bus_req.wr && bus_req.addr == 5'h0E) ##1
    (bus_req.rd && bus_req.addr == 5'h0E) |=> rd_data == $past(bus_req.wdata, 2))
    else $error("buffer read back differs");
  AST_SHUT: assert property ((shutdown_in != 4'h0) [*4] |-> pwm_oe == 6'h00)
    else $error("outputs driven during shutdown");
  AST_HALT: assert property (clk_halt_in [*4] |-> pwm_oe == 6'h00)
    else $error("outputs driven during clock halt");
  AST_OE_ALL: assert property (pwm_oe == 6'h00 || pwm_oe == 6'h3F)
    else $error("output enables split");
  AST_ADC: assert property (adc_start_req |=> !adc_start_req)
    else $error("conversion request longer than one cycle");
  AST_TOG_INIT: assert property ($fell(reset) |-> toggle_out)
    else $error("toggle pin not one after reset");
  // main scenarios reached
  cover property (adc_start_req);
  cover property ($changed(toggle_out));
  cover property (pwm_oe == 6'h3F);
endmodule // cpwm_top_chk

bind cpwm_top cpwm_top_chk #(.CW(CW)) u_chk (.sys_clk(sys_clk),
  .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
  .shutdown_in(shutdown_in), .clk_halt_in(clk_halt_in), .pwm_oe(pwm_oe),
  .toggle_out(toggle_out), .adc_start_req(adc_start_req));

// file: test/cpwm_stage_model.sv
// power stage model: gate drivers behind the six pwm pins
// assumes pull-downs on the gate inputs, high active switches
`timescale 1ns/1ps
module cpwm_stage_model (
  // pins from the block
  input wire logic [5:0] pwm_out,
  input wire logic [5:0] pwm_oe,
  // gate levels and leg short flag
  output logic [5:0]     gate,
  output logic           overlap
);
  // a released pin falls to the pull-down level
  assign gate = pwm_out & pwm_oe;
  // both switches of one leg on at once
  assign overlap = |(gate[2:0] & gate[5:3]);
endmodule // cpwm_stage_model

// file: test/cpwm_tb.sv
// self-checking bench for the complementary pwm output block
// assumes cpwm_top, the power stage model and the port checker
`timescale 1ns/1ps
`include "cpwm_cfg.svh"
module tb;
  logic                    sys_clk, reset, clk_halt_in, sync_clear_in;
  cpwm_pkg::cpwm_bus_req_t bus_req;
  logic [15:0]             rd_data;
  logic [2:0]              hall_in;
  logic [3:0]              shutdown_in;
  logic [5:0]              pwm_out, pwm_oe, gate;
  logic                    toggle_out, adc_start_req, overlap;
  int                      n_errors, checked;
  cpwm_top u_dut (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
    .rd_data(rd_data), .hall_in(hall_in), .shutdown_in(shutdown_in),
    .clk_halt_in(clk_halt_in), .sync_clear_in(sync_clear_in),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .toggle_out(toggle_out),
    .adc_start_req(adc_start_req));
  cpwm_stage_model u_stage (.pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .gate(gate), .overlap(overlap));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task chk(string nm, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(logic [4:0] a, logic [15:0] d);
    @(posedge sys_clk) bus_req <= '{a, d, 1'b1, 1'b0};
  endtask
  task wt(int n);
    @(posedge sys_clk) bus_req <= '0;
    repeat (n) @(posedge sys_clk);
  endtask
  task rd(logic [4:0] a, logic [15:0] e, string nm);
    @(posedge sys_clk) bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk) bus_req <= '0;
    @(negedge sys_clk) chk(nm, e, rd_data);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    chk("toggle", 16'h0001, {15'h0000, toggle_out});
    rd(`CPWM_OFS_PROT, 16'h2000, "prot");
    wr(`CPWM_OFS_BUF4, 16'h1234);
    rd(`CPWM_OFS_BUF4, 16'h1234, "buf4");
    rd(5'h1F, 16'h0000, "unmapped");
    wr(`CPWM_OFS_PROT, 16'h0000);
    wr(`CPWM_OFS_DEAD, 16'h0005);
    rd(`CPWM_OFS_DEAD, 16'h0000, "dead closed");
    wr(`CPWM_OFS_BUF0, 16'h0077);
    rd(`CPWM_OFS_BUF0, 16'h0077, "buf0 open");
    wr(`CPWM_OFS_PROT, 16'h2000);
    rd(`CPWM_OFS_DEAD, 16'h0000, "dead kept");
  endtask
  task t_run;
    int nu, nv, ns, na, nt;
    logic tp;
    nu = 0; nv = 0; ns = 0; na = 0; nt = 0;
    wr(`CPWM_OFS_DEAD, 16'h0002);
    wr(`CPWM_OFS_BUF0, 16'h000C);
    wr(`CPWM_OFS_BUF0 + 5'h01, 16'h000A);
    wr(`CPWM_OFS_BUF0 + 5'h02, 16'h0000);
    wr(`CPWM_OFS_BUF0 + 5'h03, 16'h000C);
    wr(`CPWM_OFS_BUF4, 16'h0006);
    wr(`CPWM_OFS_OCTL, 16'h01FF);
    wr(`CPWM_OFS_MODE, 16'h000F);
    wt(60);
    tp = toggle_out;
    repeat (200) begin
      @(negedge sys_clk);
      if (pwm_out[0] !== 1'b1 || pwm_out[3] !== 1'b0) nu++;
      if (pwm_out[1] !== 1'b0) nv++;
      if (overlap !== 1'b0) ns++;
      if (adc_start_req === 1'b1) na++;
      if (toggle_out !== tp) nt++;
      tp = toggle_out;
    end
    chk("oe run", 16'h003F, {10'h000, pwm_oe});
    chk("u full duty", 16'h0000, nu[15:0]);
    chk("v zero duty", 16'h0000, nv[15:0]);
    chk("leg overlap", 16'h0000, ns[15:0]);
    chk("adc seen", 16'h0001, {15'h0000, na != 0});
    chk("toggle seen", 16'h0001, {15'h0000, nt != 0});
  endtask
  task t_upd;
    wr(`CPWM_OFS_BUF0 + 5'h03, 16'h0000);
    wr(`CPWM_OFS_BUF4, 16'h0006);
    wt(50);
    rd(`CPWM_OFS_CMP0 + 5'h03, 16'h0000, "cmp v");
  endtask
  task t_sync;
    wr(`CPWM_OFS_SYNC, 16'h0007);
    @(posedge sys_clk) begin
      bus_req       <= '0;
      sync_clear_in <= 1'b1;
    end
    @(posedge sys_clk) sync_clear_in <= 1'b0;
    rd(`CPWM_OFS_CNTA, 16'h0003, "cnt a clear");
  endtask
  task t_motor;
    wr(`CPWM_OFS_GATE, 16'h0017);
    wt(6);
    chk("phase bits", 16'h0011, {10'h000, pwm_out});
    wr(`CPWM_OFS_GATE, 16'h0057);
    wt(6);
    chk("neg chop", 16'h0001, {10'h000, pwm_out});
    wr(`CPWM_OFS_GATE, 16'h0001);
    @(posedge sys_clk) begin
      bus_req <= '0;
      hall_in <= 3'b010;
    end
    wt(8);
    chk("hall", 16'h000A, {10'h000, pwm_out});
  endtask
  task t_stop;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) {clk_halt_in, shutdown_in} <= 5'h01 << i;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) chk("oe off", 16'h0000, {10'h000, pwm_oe});
      @(posedge sys_clk) {clk_halt_in, shutdown_in} <= 5'h00;
      repeat (6) @(posedge sys_clk);
    end
  endtask
  // ************************************************************
  // clock, main sequence and watchdog
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    reset = 1'b1; bus_req = '0; hall_in = 3'b000; shutdown_in = 4'h0;
    clk_halt_in = 1'b0; sync_clear_in = 1'b0; n_errors = 0; checked = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    t_run;
    t_upd;
    t_sync;
    t_motor;
    t_stop;
    stop_test;
  end
  initial begin
    #500000;
    n_errors++;
    stop_test;
  end
endmodule // tb
